/* test/pbet_loopback.sv */
// Loopback partner returning the transmit stream
`timescale 1ns/100ps
`default_nettype none
module pbet_loopback (
  input wire logic pclk,
  input wire logic tx_bit,
  input wire logic flip,
  input wire logic noise_en,
  input wire logic noise,
  output logic rx_bit
);
  // One bit of line delay; flip corrupts a bit, noise replaces the stream
  always @(posedge pclk) rx_bit <= noise_en ? noise : tx_bit ^ flip;
endmodule
`default_nettype wire

/* test/pbet_tester_props.sv */
// Port assertions of the pattern tester
`timescale 1ns/100ps
`default_nettype none
module pbet_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_pol_pin,
  input wire logic tx_bit,
  input wire logic rx_pol_invert,
  input wire logic tx_pol_invert,
  input wire logic [1:0] squelch_threshold_select
);
  logic [3:0] ctl_reg;
  wire logic setup = psel && !penable;
  // Shadow of enable and pattern code, taken at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctl_reg <= 4'h0;
    else if (psel && penable && pready && pwrite && paddr == 10'h05C) ctl_reg <= pwdata[3:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_pol_wr; psel && penable && pready && pwrite && paddr == 10'h06C; endsequence
  sequence s_alt; (ctl_reg[0] && ctl_reg[3:2] == 2'h3) [*4]; endsequence
  property p_ans; setup |=> pready && penable; endproperty
  a_ans: assert property (p_ans) else $error("no answer after setup");
  property p_err; setup && !(paddr inside {10'h05C, 10'h060, 10'h064, 10'h06C}) |=> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside answer");
  property p_sq; s_pol_wr |-> ##2 squelch_threshold_select == $past(pwdata[1:0], 2); endproperty
  a_sq: assert property (p_sq) else $error("squelch select wrong");
  property p_polw; s_pol_wr |-> ##2 {rx_pol_invert, tx_pol_invert} == $past(pwdata[15:14], 2); endproperty
  a_polw: assert property (p_polw) else $error("polarity after write wrong");
  property p_pin; $rose(rx_pol_pin) |-> ##[1:5] rx_pol_invert; endproperty
  a_pin: assert property (p_pin) else $error("pin edge ignored");
  property p_off; !ctl_reg[0] [*2] |-> !tx_bit; endproperty
  a_off: assert property (p_off) else $error("generator runs while off");
  property p_alt; s_alt |-> tx_bit != $past(tx_bit); endproperty
  a_alt: assert property (p_alt) else $error("pattern not alternating");
endmodule
bind pbet_tester pbet_props pbet_props_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .rx_pol_pin, .tx_bit, .rx_pol_invert, .tx_pol_invert, .squelch_threshold_select);
`default_nettype wire

/* test/pbet_tester_tb_top.sv */
// Self-checking bench of the pattern tester
`timescale 1ns/100ps
`default_nettype none
module pbet_tester_tb_top;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic rx_pol_pin = 1'h0, tx_pol_pin = 1'h0, flip = 1'h0, noise_en = 1'h0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0, lfsr = 32'hF8E37E3D, prdata, v;
  logic pready, pslverr, rx_bit, tx_bit, rx_pol_invert, tx_pol_invert;
  logic [1:0] squelch_threshold_select;
  logic [33:0] expq[$], e;
  int error_cnt = 0, comparisons = 0;
  always #50 pclk = ~pclk;
  pbet_tester pbet_tester_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_bit, .rx_pol_pin, .tx_pol_pin, .tx_bit, .rx_pol_invert, .tx_pol_invert, .squelch_threshold_select);
  pbet_loopback pbet_loopback_inst (.pclk, .tx_bit, .flip, .noise_en, .noise(lfsr[0]), .rx_bit);
  function automatic logic [31:0] nxt(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge pclk) lfsr <= nxt(lfsr);
  task automatic chk(string s, logic [31:0] x, logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge pclk);
  endtask
  // Setup edge, then access held until pready is sampled high
  task automatic apb(logic w, logic [9:0] a, logic [31:0] d, logic [33:0] x);
    int n = 0;
    expq.push_back(x);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      error_cnt++;
      tally_and_finish;
    end
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(logic [9:0] a, logic [31:0] d); apb(1'h1, a, d, 34'h0); endtask
  task automatic rd(logic [9:0] a, logic [31:0] d); apb(1'h0, a, 32'h0, {2'h0, d}); endtask
  task automatic rdnz(logic [9:0] a); apb(1'h0, a, 32'h0, {2'h2, 32'h0}); endtask
  // Answers are compared in request order
  always @(posedge pclk) begin
    if (pready === 1'h1) begin
      e = expq.pop_front();
      chk("error flag", {31'h0, e[32]}, {31'h0, pslverr});
      if (e[33]) chk("count nonzero", 32'h1, {31'h0, prdata != 32'h0});
      else chk("read data", e[31:0], prdata);
    end
  end
  initial begin
    cyc(2);
    presetn <= 1'h1;
    rd(10'h05C, 32'h0);
    rd(10'h060, 32'h0);
    rd(10'h064, 32'h0);
    apb(1'h1, 10'h070, 32'hFFFF, {2'h1, 32'h0});
    apb(1'h0, 10'h070, 32'h0, {2'h1, 32'h0});
    $display("test reset and map done");
    for (int i = 0; i < 4; i++) begin
      v = {18'h0, lfsr[13:2], i[1:0]};
      wr(10'h06C, v);
      rd(10'h06C, v);
      chk("squelch", i, {30'h0, squelch_threshold_select});
    end
    wr(10'h06C, 32'hC000);
    cyc(1);
    chk("polarity", 32'h3, {30'h0, rx_pol_invert, tx_pol_invert});
    wr(10'h06C, 32'h0);
    rx_pol_pin <= 1'h1;
    tx_pol_pin <= 1'h1;
    cyc(8);
    rd(10'h06C, 32'hC000);
    wr(10'h06C, 32'h0);
    rd(10'h06C, 32'h0);
    $display("test polarity and squelch done");
    // Checker must drop lock between patterns, so both sides go off first
    for (int p = 0; p < 4; p++) begin
      v = 32'h23 | (p << 2) | (p[0] ? 32'hC0 : 32'h0);
      wr(10'h05C, 32'h0);
      wr(10'h05C, v);
      cyc(120);
      wr(10'h05C, v | 32'h10);
      rd(10'h05C, v);
      repeat (5) begin
        @(posedge pclk);
        flip <= 1'h1;
        @(posedge pclk);
        flip <= 1'h0;
      end
      cyc(4);
      rd(10'h060, 32'h5);
      rd(10'h064, 32'h0);
    end
    $display("test pattern loopback done");
    // Generator inverted alone: every checked bit must disagree
    wr(10'h05C, 32'h0);
    wr(10'h05C, 32'h43);
    cyc(60);
    wr(10'h05C, 32'h53);
    cyc(20);
    wr(10'h05C, 32'h0);
    rdnz(10'h060);
    wr(10'h05C, 32'h0);
    noise_en <= 1'h1;
    wr(10'h05C, 32'h32);
    cyc(200);
    rd(10'h060, 32'h0);
    wr(10'h05C, 32'h02);
    cyc(50);
    wr(10'h05C, 32'h0);
    rdnz(10'h060);
    rd(10'h064, 32'h0);
    wr(10'h05C, 32'h10);
    cyc(50);
    rd(10'h060, 32'h0);
    $display("test lock gating and clear done");
    cyc(3);
    tally_and_finish;
  end
endmodule
`default_nettype wire

/* verilog/pbet_consts.vh */
// Register map, field positions, reset values and pattern codes of the pattern tester
`ifndef PBET_CONSTS_VH
`define PBET_CONSTS_VH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define PBET_IDX_CTRL 8'h17
`define PBET_IDX_CNT_LO 8'h18
`define PBET_IDX_CNT_HI 8'h19
`define PBET_IDX_POL 8'h1B
`define PBET_ADDR_CTRL 10'h05C
`define PBET_ADDR_CNT_LO 10'h060
`define PBET_ADDR_CNT_HI 10'h064
`define PBET_ADDR_POL 10'h06C

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define PBET_CTRL_GEN_EN 0
`define PBET_CTRL_CHK_EN 1
`define PBET_CTRL_PAT_LO 2
`define PBET_CTRL_PAT_HI 3
`define PBET_CTRL_CLEAR 4
`define PBET_CTRL_LOCK_GATE 5
`define PBET_CTRL_GEN_INV 6
`define PBET_CTRL_CHK_INV 7

// ----------------------------------------
// Polarity field positions
// ----------------------------------------
`define PBET_POL_RX_INV 15
`define PBET_POL_TX_INV 14
`define PBET_POL_SQ_LO 0
`define PBET_POL_SQ_HI 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PBET_CTRL_RESET 16'h0000
`define PBET_POL_RESET 16'h0000
`define PBET_CNT_RESET 32'h00000000

// ----------------------------------------
// Pattern codes and lock count
// ----------------------------------------
`define PBET_PAT_P7 2'h0
`define PBET_PAT_P23 2'h1
`define PBET_PAT_P31 2'h2
`define PBET_PAT_ALT 2'h3
`define PBET_LOCK_GOOD 6'h20

`endif

/* verilog/pbet_lfsr.v */
// Pattern sequence register: PRBS7/23/31 or alternating bits
`timescale 1ns/100ps
`default_nettype none
`include "pbet_consts.vh"

module pbet_lfsr (
  input wire pclk,
  input wire presetn,
  input wire run,
  input wire [1:0] pat_sel,
  input wire load,
  input wire load_bit,
  output wire pat_bit
);

  reg [30:0] state_reg;
  reg [30:0] state_next;
  reg fb;
  reg [30:0] used_mask;

  // ----------------------------------------
  // Feedback per pattern
  // ----------------------------------------
  // [R1] Pattern selection
  always @* begin
    used_mask = 31'h7FFFFFFF;
    case (pat_sel)
      `PBET_PAT_P7: begin
        fb = state_reg[6] ^ state_reg[5];
        used_mask = 31'h0000007F;
      end
      `PBET_PAT_P23: begin
        fb = state_reg[22] ^ state_reg[17];
        used_mask = 31'h007FFFFF;
      end
      `PBET_PAT_P31: fb = state_reg[30] ^ state_reg[27];
      default: fb = ~state_reg[0];
    endcase
    // Loading with received bits lets the checker seed itself
    if (load) begin
      state_next = {state_reg[29:0], load_bit};
    end else begin
      state_next = {state_reg[29:0], fb};
    end
    // Only the active stages matter: stale upper bits hide a lock-up
    if (!load && (state_next & used_mask) == 31'h00000000) begin
      state_next = 31'h00000001;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= 31'h00000001;
    end else if (run) begin
      state_reg <= state_next;
    end
  end

  assign pat_bit = fb;

endmodule
`default_nettype wire

/* verilog/pbet_sync.v */
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none

module pbet_sync #(
  parameter WIDTH = 1
) (
  input wire pclk,
  input wire presetn,
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] s1_reg;
  reg [WIDTH-1:0] s2_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= {WIDTH{1'b0}};
      s2_reg <= {WIDTH{1'b0}};
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
    end
  end

  assign dout = s2_reg;

endmodule
`default_nettype wire

/* verilog/pbet_tester.v */
// Pattern bit error tester with APB register access
// Contract
// [R1] Two-bit code picks PRBS7, PRBS23, PRBS31 or alternating one-zero pattern.
// [R2] Control bit 0 enables generator, bit 1 enables checker.
// [R3] With lock gating set, counting waits until checker has locked.
// [R4] Writing clear bit zeroes counter; bit returns to zero by itself.
// [R5] Bit 7 inverts expected pattern, bit 6 inverts generator output.
// [R6] Reading low half captures high half for one consistent snapshot.
// [R7] Software reads low half before high half.
// [R8] Bits 15/14 invert rx/tx polarity; latest of write or pin wins.
// [R9] Two-bit field selects squelch threshold 30, 60, 90 or 120 mV.
// [R10] Each mismatching received bit increments counter while counting permitted.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "pbet_consts.vh"

module pbet_tester (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rx_bit,
  input wire rx_pol_pin,
  input wire tx_pol_pin,
  output reg tx_bit,
  output reg rx_pol_invert,
  output reg tx_pol_invert,
  output reg [1:0] squelch_threshold_select
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [15:0] ctrl_reg;
  reg [15:0] pol_reg;
  reg [31:0] cnt_reg;
  reg [15:0] cnt_hi_snap_reg;
  reg locked_reg;
  reg [5:0] good_run_reg;
  reg rx_pol_pin_d_reg;
  reg tx_pol_pin_d_reg;
  reg rx_pol_invert_next;
  reg tx_pol_invert_next;
  reg [31:0] cnt_next;
  reg [15:0] ctrl_next;
  reg [15:0] pol_next;
  reg locked_next;
  reg [5:0] good_run_next;
  reg [31:0] prdata_next;
  reg pslverr_next;

  wire rx_bit_s;
  wire rx_pol_pin_s;
  wire tx_pol_pin_s;
  wire gen_bit;
  wire exp_bit;

  wire setup = psel && !penable;
  // Writes land on the access edge, when the answer is sampled
  wire acc_phase = psel && penable && pready;
  wire wr_en = acc_phase && pwrite;
  wire rd_en = setup && !pwrite;
  wire gen_en = ctrl_reg[`PBET_CTRL_GEN_EN];
  wire chk_en = ctrl_reg[`PBET_CTRL_CHK_EN];
  wire [1:0] pat_sel = ctrl_reg[`PBET_CTRL_PAT_HI:`PBET_CTRL_PAT_LO];
  wire clear_cnt = ctrl_reg[`PBET_CTRL_CLEAR];
  wire lock_gate = ctrl_reg[`PBET_CTRL_LOCK_GATE];

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire hit_ctrl = (paddr == `PBET_ADDR_CTRL);
  wire hit_cnt_lo = (paddr == `PBET_ADDR_CNT_LO);
  wire hit_cnt_hi = (paddr == `PBET_ADDR_CNT_HI);
  wire hit_pol = (paddr == `PBET_ADDR_POL);
  wire hit_any = hit_ctrl || hit_cnt_lo || hit_cnt_hi || hit_pol;
  wire rd_lo = rd_en && hit_cnt_lo;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Data and pin controls kept apart; each is its own stream
  pbet_sync #(.WIDTH(1)) u_sync_rx (
    .pclk(pclk),
    .presetn(presetn),
    .din(rx_bit),
    .dout(rx_bit_s)
  );

  pbet_sync #(.WIDTH(2)) u_sync_pin (
    .pclk(pclk),
    .presetn(presetn),
    .din({rx_pol_pin, tx_pol_pin}),
    .dout({rx_pol_pin_s, tx_pol_pin_s})
  );

  // ----------------------------------------
  // Generator and checker
  // ----------------------------------------
  // [R2] Generator runs when enabled
  pbet_lfsr u_gen (
    .pclk(pclk),
    .presetn(presetn),
    .run(gen_en),
    .pat_sel(pat_sel),
    .load(1'b0),
    .load_bit(1'b0),
    .pat_bit(gen_bit)
  );

  // [R5] Checker compares after undoing inversion
  wire rx_norm = rx_bit_s ^ ctrl_reg[`PBET_CTRL_CHK_INV];
  wire mismatch = rx_norm != exp_bit;

  // Self-synchronising: seeded from the stream until locked
  pbet_lfsr u_chk (
    .pclk(pclk),
    .presetn(presetn),
    .run(chk_en),
    .pat_sel(pat_sel),
    .load(!locked_reg),
    .load_bit(rx_norm),
    .pat_bit(exp_bit)
  );

  // Lock after a run of matching bits
  always @* begin
    locked_next = locked_reg;
    good_run_next = good_run_reg;
    if (!chk_en) begin
      locked_next = 1'b0;
      good_run_next = 6'h00;
    end else if (!locked_reg) begin
      if (mismatch) begin
        good_run_next = 6'h00;
      end else if (good_run_reg == `PBET_LOCK_GOOD) begin
        locked_next = 1'b1;
      end else begin
        good_run_next = good_run_reg + 6'h01;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked_reg <= 1'b0;
      good_run_reg <= 6'h00;
    end else begin
      locked_reg <= locked_next;
      good_run_reg <= good_run_next;
    end
  end

  // [R5] Generator output inversion
  wire tx_bit_next = gen_en & (gen_bit ^ ctrl_reg[`PBET_CTRL_GEN_INV]);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_bit <= 1'b0;
    end else begin
      tx_bit <= tx_bit_next;
    end
  end

  // ----------------------------------------
  // Error counter
  // ----------------------------------------
  // [R3] Lock gating of counting
  wire count_ok = chk_en && (!lock_gate || locked_reg);

  always @* begin
    cnt_next = cnt_reg;
    // [R4] Clear only via clear bit
    if (clear_cnt) begin
      cnt_next = `PBET_CNT_RESET;
    // [R10] One count per mismatching bit; saturates
    end else if (count_ok && mismatch && cnt_reg != 32'hFFFFFFFF) begin
      cnt_next = cnt_reg + 32'h00000001;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= `PBET_CNT_RESET;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // [R6] Low read captures high half
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_hi_snap_reg <= 16'h0000;
    end else if (clear_cnt) begin
      cnt_hi_snap_reg <= 16'h0000;
    end else if (rd_lo) begin
      cnt_hi_snap_reg <= cnt_reg[31:16];
    end
  end

  // ----------------------------------------
  // Control and polarity registers
  // ----------------------------------------
  always @* begin
    ctrl_next = ctrl_reg;
    // [R4] Clear bit self-clears
    ctrl_next[`PBET_CTRL_CLEAR] = 1'b0;
    if (wr_en && hit_ctrl) begin
      ctrl_next = pwdata[15:0];
    end
  end

  always @* begin
    pol_next = pol_reg;
    if (wr_en && hit_pol) begin
      pol_next = pwdata[15:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `PBET_CTRL_RESET;
      pol_reg <= `PBET_POL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
      pol_reg <= pol_next;
    end
  end

  // [R8] Latest event of write or pin edge wins
  always @* begin
    rx_pol_invert_next = rx_pol_invert;
    tx_pol_invert_next = tx_pol_invert;
    if (rx_pol_pin_s != rx_pol_pin_d_reg) begin
      rx_pol_invert_next = rx_pol_pin_s;
    end
    if (tx_pol_pin_s != tx_pol_pin_d_reg) begin
      tx_pol_invert_next = tx_pol_pin_s;
    end
    // A same-cycle write beats a pin change
    if (wr_en && hit_pol) begin
      rx_pol_invert_next = pwdata[`PBET_POL_RX_INV];
      tx_pol_invert_next = pwdata[`PBET_POL_TX_INV];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_pol_pin_d_reg <= 1'b0;
      tx_pol_pin_d_reg <= 1'b0;
      rx_pol_invert <= 1'b0;
      tx_pol_invert <= 1'b0;
      squelch_threshold_select <= 2'h0;
    end else begin
      rx_pol_pin_d_reg <= rx_pol_pin_s;
      tx_pol_pin_d_reg <= tx_pol_pin_s;
      rx_pol_invert <= rx_pol_invert_next;
      tx_pol_invert <= tx_pol_invert_next;
      // [R9] Squelch threshold code
      squelch_threshold_select <= pol_reg[`PBET_POL_SQ_HI:`PBET_POL_SQ_LO];
    end
  end

  // ----------------------------------------
  // APB slave: answer one cycle after setup
  // ----------------------------------------
  // Read data formed at setup, so a low read and its snapshot agree
  always @* begin
    prdata_next = 32'h00000000;
    pslverr_next = 1'b0;
    if (setup) begin
      if (!hit_any) begin
        // Unmapped offsets are refused, writes there are dropped
        pslverr_next = 1'b1;
      end else if (!pwrite) begin
        if (hit_ctrl) begin
          prdata_next = {16'h0000, ctrl_reg};
        end
        if (hit_cnt_lo) begin
          prdata_next = {16'h0000, cnt_reg[15:0]};
        end
        // High half shows last snapshot
        if (hit_cnt_hi) begin
          prdata_next = {16'h0000, cnt_hi_snap_reg};
        end
        if (hit_pol) begin
          prdata_next = {16'h0000, rx_pol_invert, tx_pol_invert, pol_reg[13:0]};
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= pslverr_next;
      prdata <= prdata_next;
    end
  end

endmodule
`default_nettype wire
